// ==== shcp_host_model.sv ====
// Host model: serial bus master that drives select, clock and data lanes.
`timescale 1ns/100ps
`default_nettype none
module shcp_host_model (
  input wire logic clk_sys_in, // System clock, paces the floating pattern.
  input wire logic [3:0] lane_out_in, // Device lane values.
  input wire logic [3:0] lane_oe_in, // Device lane enables.
  output logic sck_out, // Serial clock, rests low between transfers.
  output logic cs_n_out, // Chip select, active low.
  output logic [3:0] lane_w_out // Resolved lane wires.
);
  logic [3:0] drv = 4'h0;
  logic [3:0] val = 4'h0;
  logic [3:0] idle = 4'h5;
  int width = 1;

  // A lane nobody drives flips every cycle, so stale data never passes as valid.
  always @(posedge clk_sys_in) idle <= ~idle;

  // Device enables win, then the host, else the floating pattern.
  assign lane_w_out = (lane_oe_in & lane_out_in) | (~lane_oe_in & drv & val) | (~lane_oe_in & ~drv & idle);

  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
  end

  // Select, then leave the device time to see it before the first edge.
  task automatic open_frame();
    cs_n_out = 1'b0;
    #400;
  endtask : open_frame

  // Release lanes and select; the clock already rests low.
  task automatic close_frame();
    #200;
    cs_n_out = 1'b1;
    drv = 4'h0;
    #400;
  endtask : close_frame

  // One byte, MSB first, in groups of the lane width; data changes on the falling edge.
  // The answer is sampled late in the high phase because it trails the falling edge.
  task automatic xfer(input logic [7:0] tx, input bit host_drives, output logic [7:0] rx);
    logic [3:0] mask;
    mask = (width == 1) ? 4'h1 : (width == 2) ? 4'h3 : 4'hF;
    drv = (host_drives || width == 1) ? mask : 4'h0;
    for (int i = 8 - width; i >= 0; i -= width) begin
      val = 4'(tx >> i) & mask;
      #200 sck_out = 1'b1;
      #190;
      rx = (rx << width) | ((width == 1) ? 8'(lane_w_out[1]) : 8'(lane_w_out & mask));
      #10 sck_out = 1'b0;
    end
  endtask : xfer
endmodule : shcp_host_model
`default_nettype wire

// ==== shcp_host_port.sv ====
// Serial slave port with lane width control, command FIFO and command engine.
`timescale 1ns/100ps
`default_nettype none
module shcp_host_port
  import shcp_pkg::*;
#(
  parameter int unsigned MS_CYCLES_P = MS_CYCLES
) (
  input wire logic clk_sys_in, // System clock, 20 MHz.
  input wire logic arst_n_in, // Asynchronous reset, active low.
  input wire logic sck_in, // Serial clock from the host.
  input wire logic cs_n_in, // Chip select, active low.
  input wire logic [3:0] lane_in, // Lanes 0..3; 2 and 3 share general pins zero and one.
  output logic [3:0] lane_out, // Lane output values.
  output logic [3:0] lane_oe_out, // Lane output enables, high while driving.
  output logic int_n_out // Interrupt to host, active low.
);

  // ----------------------------------------------------------------
  // Input synchronisers: three flops, accepted when stages 2 and 3 agree.
  // ----------------------------------------------------------------
  logic [5:0] raw_w, sy1_q, sy2_q, sy3_q, st_q;
  assign raw_w = {lane_in, cs_n_in, sck_in};
  for (genvar i = 0; i < 6; i++) begin : g_sync
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        sy1_q[i] <= SYNC_RST[i];
        sy2_q[i] <= SYNC_RST[i];
        sy3_q[i] <= SYNC_RST[i];
        st_q[i] <= SYNC_RST[i];
      end else begin
        sy1_q[i] <= raw_w[i];
        sy2_q[i] <= sy1_q[i];
        sy3_q[i] <= sy2_q[i];
        if (sy2_q[i] == sy3_q[i]) begin
          st_q[i] <= sy3_q[i];
        end
      end
    end
  end

  logic sck_rise_w, sck_fall_w, cs_hi_w;
  assign sck_rise_w = !st_q[0] && sy2_q[0] && sy3_q[0];
  assign sck_fall_w = st_q[0] && !sy2_q[0] && !sy3_q[0];
  assign cs_hi_w = st_q[1];

  // ----------------------------------------------------------------
  // Serial framing.
  // ----------------------------------------------------------------
  logic [1:0] width_q, lane_mode_q, hdr_cnt_q;
  logic [11:0] wr_ptr_q, rd_ptr_q, fetch_q, addr_q, acc_addr_w;
  logic [7:0] hdr0_q, hdr1_q, rx_q, rx_d, tx_q, rdata_w;
  logic [7:0] cmd_mem [FIFO_BYTES];
  logic [3:0] lane_out_q, lane_oe_q, step_w;
  logic [2:0] bits_q;
  logic byte_done_w, hdr_done_w, rd_load_w, reg_wr_w, fifo_push_w, int_n_q, overrun_q;
  logic eng_rd_w, timer_done_w;
  shcp_phase_type phase_q;
  shcp_eng_type eng_q;

  // Bits per serial edge follow the lane mode; the reserved code acts as single.
  always_comb begin
    step_w = 4'h1;
    rx_d = {rx_q[6:0], sy3_q[2]};
    case (lane_mode_q)
      LANE_DUAL: begin
        step_w = 4'h2;
        rx_d = {rx_q[5:0], sy3_q[3], sy3_q[2]};
      end
      LANE_QUAD: begin
        step_w = 4'h4;
        rx_d = {rx_q[3:0], sy3_q[5:2]};
      end
      default: begin
        step_w = 4'h1;
        rx_d = {rx_q[6:0], sy3_q[2]};
      end
    endcase
  end

  assign byte_done_w = sck_rise_w && !cs_hi_w && (({1'b0, bits_q} + step_w) == 4'h8);
  assign hdr_done_w = byte_done_w && (phase_q == PH_HDR) && (hdr_cnt_q == 2'h2);
  assign acc_addr_w = (phase_q == PH_HDR) ? {hdr1_q[3:0], rx_d} : addr_q;
  assign rd_load_w = (hdr_done_w && !hdr0_q[HDR_WRITE_BIT]) || (byte_done_w && phase_q == PH_READ);
  assign reg_wr_w = byte_done_w && (phase_q == PH_WRITE) && !hdr0_q[HDR_FIFO_BIT];
  assign fifo_push_w = byte_done_w && (phase_q == PH_WRITE) && hdr0_q[HDR_FIFO_BIT];

  // Header is three bytes: flags, address high nibble, address low byte.
  // While deselected all framing is held idle so bus noise is ignored.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_q <= PH_HDR;
      hdr_cnt_q <= 2'h0;
      bits_q <= 3'h0;
      rx_q <= 8'h00;
      hdr0_q <= 8'h00;
      hdr1_q <= 8'h00;
      addr_q <= 12'h000;
    end else if (cs_hi_w) begin
      phase_q <= PH_HDR;
      hdr_cnt_q <= 2'h0;
      bits_q <= 3'h0;
    end else if (sck_rise_w) begin
      rx_q <= rx_d;
      bits_q <= 3'(bits_q + step_w[2:0]);
      if (byte_done_w && phase_q == PH_HDR) begin
        hdr_cnt_q <= 2'(hdr_cnt_q + 2'h1);
        if (hdr_cnt_q == 2'h0) begin
          hdr0_q <= rx_d;
        end
        if (hdr_cnt_q == 2'h1) begin
          hdr1_q <= rx_d;
        end
        if (hdr_cnt_q == 2'h2) begin
          phase_q <= hdr0_q[HDR_WRITE_BIT] ? PH_WRITE : PH_READ;
          addr_q <= hdr0_q[HDR_WRITE_BIT] ? acc_addr_w : 12'(acc_addr_w + 12'h001);
        end
      end else if (byte_done_w) begin
        addr_q <= 12'(addr_q + 12'h001); // Wraps, so the FIFO space is circular.
      end
    end
  end

  // Read data mux over FIFO memory and registers; unmapped reads give zero.
  always_comb begin
    rdata_w = 8'h00;
    if (hdr0_q[HDR_FIFO_BIT]) begin
      rdata_w = cmd_mem[acc_addr_w];
    end else if (acc_addr_w == REG_LANE_WIDTH) begin
      rdata_w = {6'h00, width_q};
    end else if (acc_addr_w == REG_CMD_WR_LO) begin
      rdata_w = wr_ptr_q[7:0];
    end else if (acc_addr_w == REG_CMD_WR_HI) begin
      rdata_w = {4'h0, wr_ptr_q[11:8]};
    end else if (acc_addr_w == REG_CMD_RD_LO) begin
      rdata_w = rd_ptr_q[7:0];
    end else if (acc_addr_w == REG_CMD_RD_HI) begin
      rdata_w = {4'h0, rd_ptr_q[11:8]};
    end else if (acc_addr_w == REG_INT_FLAG) begin
      rdata_w = {7'h00, ~int_n_q};
    end else if (acc_addr_w == REG_STATUS) begin
      rdata_w = {7'h00, overrun_q};
    end
  end

  // Transmit shifter: loaded on a rising edge, shifted out on falling edges.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_q <= 8'h00;
      lane_out_q <= 4'h0;
    end else if (rd_load_w) begin
      tx_q <= rdata_w;
    end else if (sck_fall_w && !cs_hi_w) begin
      case (lane_mode_q)
        LANE_QUAD: begin
          lane_out_q <= tx_q[7:4];
          tx_q <= {tx_q[3:0], 4'h0};
        end
        LANE_DUAL: begin
          lane_out_q <= {2'b00, tx_q[7:6]};
          tx_q <= {tx_q[5:0], 2'b00};
        end
        default: begin
          lane_out_q <= {2'b00, tx_q[7], 1'b0};
          tx_q <= {tx_q[6:0], 1'b0};
        end
      endcase
    end
  end

  // Output enables: single drives lane one only; wide modes turn around after the header.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lane_oe_q <= 4'h0;
    end else if (cs_hi_w) begin
      lane_oe_q <= 4'h0;
    end else begin
      case (lane_mode_q)
        LANE_DUAL: lane_oe_q <= (phase_q == PH_READ) ? 4'h3 : 4'h0;
        LANE_QUAD: lane_oe_q <= (phase_q == PH_READ) ? 4'hF : 4'h0;
        default: lane_oe_q <= 4'h2;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers. The lane mode only follows the field while deselected,
  // so a width change never splits a byte across two lane counts.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      width_q <= LANE_WIDTH_RST;
      lane_mode_q <= LANE_WIDTH_RST;
      wr_ptr_q <= 12'h000;
    end else begin
      if (cs_hi_w) begin
        lane_mode_q <= width_q;
      end
      if (reg_wr_w && acc_addr_w == REG_LANE_WIDTH) begin
        width_q <= rx_d[1:0];
      end
      if (reg_wr_w && acc_addr_w == REG_CMD_WR_LO) begin
        wr_ptr_q[7:0] <= rx_d;
      end
      if (reg_wr_w && acc_addr_w == REG_CMD_WR_HI) begin
        wr_ptr_q[11:8] <= rx_d[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // FIFO write path through the two-entry buffer.
  // ----------------------------------------------------------------
  shcp_stream_if #(.W(BUF_W)) up_if ();
  shcp_stream_if #(.W(BUF_W)) dn_if ();
  assign up_if.valid = fifo_push_w;
  assign up_if.data = {addr_q, rx_d};
  assign dn_if.ready = !eng_rd_w; // The engine owns the memory port when fetching.

  shcp_pair_buffer u_buf (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .up(up_if.sink),
    .dn(dn_if.src)
  );

  // The command memory is one array; the engine read and this write never collide.
  always_ff @(posedge clk_sys_in) begin
    if (dn_if.valid && dn_if.ready) begin
      cmd_mem[dn_if.data[BUF_W-1:8]] <= dn_if.data[7:0];
    end
  end

  // A byte that finds the buffer full is dropped and flagged; setting beats clearing.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      overrun_q <= 1'b0;
    end else if (up_if.valid && !up_if.ready) begin
      overrun_q <= 1'b1;
    end else if (reg_wr_w && acc_addr_w == REG_STATUS && rx_d[0]) begin
      overrun_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Command engine: fetches ahead, retires the read pointer on completion.
  // ----------------------------------------------------------------
  logic [19:0] tick_q;
  logic [7:0] ms_left_q;
  assign eng_rd_w = (eng_q != ENG_WAIT) && (fetch_q != wr_ptr_q);
  assign timer_done_w = (eng_q == ENG_WAIT) && (ms_left_q == 8'h00);

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      eng_q <= ENG_IDLE;
      fetch_q <= 12'h000;
      rd_ptr_q <= 12'h000;
      tick_q <= 20'h00000;
      ms_left_q <= 8'h00;
    end else begin
      case (eng_q)
        ENG_IDLE: begin
          if (eng_rd_w) begin
            fetch_q <= 12'(fetch_q + 12'h001);
            if (cmd_mem[fetch_q] == OP_TIMED_INT) begin
              eng_q <= ENG_ARG;
            end else begin
              rd_ptr_q <= 12'(fetch_q + 12'h001);
            end
          end
        end
        ENG_ARG: begin
          if (eng_rd_w) begin
            fetch_q <= 12'(fetch_q + 12'h001);
            ms_left_q <= cmd_mem[fetch_q];
            tick_q <= 20'h00000;
            eng_q <= ENG_WAIT;
          end
        end
        default: begin
          if (timer_done_w) begin
            rd_ptr_q <= fetch_q;
            eng_q <= ENG_IDLE;
          end else if (tick_q == 20'(MS_CYCLES_P - 1)) begin
            tick_q <= 20'h00000;
            ms_left_q <= 8'(ms_left_q - 8'h01);
          end else begin
            tick_q <= 20'(tick_q + 20'h00001);
          end
        end
      endcase
    end
  end

  // Pending interrupt is held low until the host writes one to clear it.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      int_n_q <= 1'b1;
    end else if (timer_done_w) begin
      int_n_q <= 1'b0;
    end else if (reg_wr_w && acc_addr_w == REG_INT_FLAG && rx_d[0]) begin
      int_n_q <= 1'b1;
    end
  end

  assign lane_out = lane_out_q;
  assign lane_oe_out = lane_oe_q;
  assign int_n_out = int_n_q;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_single_held;
    (lane_mode_q == LANE_SINGLE) ##1 (lane_mode_q == LANE_SINGLE);
  endsequence

  chk_single_lanes: assert property (s_single_held |-> !lane_oe_q[0] && lane_oe_q[3:2] == 2'b00)
    else $error("single mode drove a lane other than lane one");
  chk_mode_follow: assert property (cs_hi_w |=> lane_mode_q == $past(width_q))
    else $error("lane mode did not follow the width field while deselected");
  chk_dual_lanes: assert property ($past(lane_mode_q) == LANE_DUAL |-> lane_oe_q[3:2] == 2'b00)
    else $error("dual mode drove an upper lane");
  chk_quad_pins: assert property (lane_oe_q[2] |-> $past(lane_mode_q) == LANE_QUAD)
    else $error("general pin used as lane outside quad mode");
  chk_deselect_idle: assert property (cs_hi_w ##1 cs_hi_w |-> lane_oe_q == 4'h0)
    else $error("lanes driven while deselected");
  chk_fifo_store: assert property (dn_if.valid && dn_if.ready |=> cmd_mem[$past(dn_if.data[BUF_W-1:8])] == $past(dn_if.data[7:0]))
    else $error("buffered byte not stored in command memory");
  chk_fetch_window: assert property (eng_rd_w |-> fetch_q != wr_ptr_q && !(dn_if.valid && dn_if.ready))
    else $error("engine fetched outside the filled window");
  chk_fetch_stall: assert property (fetch_q == wr_ptr_q |=> fetch_q == $past(fetch_q))
    else $error("engine fetched past the write pointer");
  chk_retire_done: assert property (rd_ptr_q != $past(rd_ptr_q) |-> rd_ptr_q == fetch_q && $past(eng_q) != ENG_ARG)
    else $error("read pointer moved before command completed");
  chk_timer_int: assert property (timer_done_w |=> !int_n_q ##1 (eng_q == ENG_IDLE || !int_n_q))
    else $error("timed command did not raise the interrupt");
  chk_int_level: assert property ($fell(int_n_q) |-> $past(timer_done_w))
    else $error("interrupt asserted without a timer expiry");

endmodule : shcp_host_port
`default_nettype wire

// ==== shcp_pair_buffer.sv ====
// Two-entry buffer that holds FIFO writes while the memory port is busy.
`timescale 1ns/100ps
`default_nettype none
module shcp_pair_buffer
  import shcp_pkg::*;
(
  input wire logic clk_sys_in, // System clock.
  input wire logic arst_n_in, // Asynchronous reset, active low.
  shcp_stream_if.sink up, // Filling side.
  shcp_stream_if.src dn // Draining side.
);

  logic [BUF_W-1:0] ent_q [2];
  logic [1:0] cnt_q;
  logic rd_idx_q;
  logic push_w;
  logic pop_w;
  logic wr_idx_w;

  // ----------------------------------------------------------------
  // Handshake terms; full and empty come straight from the count.
  // ----------------------------------------------------------------
  assign up.ready = (cnt_q != 2'h2);
  assign dn.valid = (cnt_q != 2'h0);
  assign dn.data = ent_q[rd_idx_q];
  assign push_w = up.valid && up.ready;
  assign pop_w = dn.valid && dn.ready;
  assign wr_idx_w = rd_idx_q ^ cnt_q[0];

  // Entry storage needs no reset since the count guards it.
  always_ff @(posedge clk_sys_in) begin
    if (push_w) begin
      ent_q[wr_idx_w] <= up.data;
    end
  end

  // Occupancy and read index.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= 2'h0;
      rd_idx_q <= 1'b0;
    end else begin
      cnt_q <= 2'(cnt_q + {1'b0, push_w} - {1'b0, pop_w});
      if (pop_w) begin
        rd_idx_q <= ~rd_idx_q;
      end
    end
  end

endmodule : shcp_pair_buffer
`default_nettype wire

// ==== shcp_pkg.sv ====
// Shared constants and types of the serial host command port.
package shcp_pkg;

  // ----------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Lane width codes.
  // ----------------------------------------------------------------
  localparam logic [1:0] LANE_SINGLE = 2'h0;
  localparam logic [1:0] LANE_DUAL = 2'h1;
  localparam logic [1:0] LANE_QUAD = 2'h2;
  localparam logic [1:0] LANE_WIDTH_RST = 2'h0;

  // ----------------------------------------------------------------
  // Memory map: byte addresses inside the register space.
  // ----------------------------------------------------------------
  localparam int FIFO_BYTES = 4096;
  localparam int ADDR_W = 12;
  localparam logic [11:0] REG_LANE_WIDTH = 12'h000;
  localparam logic [11:0] REG_CMD_WR_LO = 12'h004;
  localparam logic [11:0] REG_CMD_WR_HI = 12'h005;
  localparam logic [11:0] REG_CMD_RD_LO = 12'h008;
  localparam logic [11:0] REG_CMD_RD_HI = 12'h009;
  localparam logic [11:0] REG_INT_FLAG = 12'h00C;
  localparam logic [11:0] REG_STATUS = 12'h010;

  // ----------------------------------------------------------------
  // Header byte zero fields, command opcodes, buffer width, synchroniser reset and state types.
  // ----------------------------------------------------------------
  localparam int HDR_WRITE_BIT = 7;
  localparam int HDR_FIFO_BIT = 6;
  localparam logic [7:0] OP_TIMED_INT = 8'h01;
  localparam int BUF_W = ADDR_W + 8;
  localparam logic [5:0] SYNC_RST = 6'h02;

  typedef enum logic [1:0] {
    PH_HDR = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ = 2'b10
  } shcp_phase_type;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_ARG = 2'b01,
    ENG_WAIT = 2'b10
  } shcp_eng_type;

endpackage : shcp_pkg

// ==== shcp_stream_if.sv ====
// Valid and ready stream carrier between the port modules.
`timescale 1ns/100ps
`default_nettype none
interface shcp_stream_if #(parameter int W = 20);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : shcp_stream_if
`default_nettype wire

// ==== test_spi_host_command_port.sv ====
// Self-checking bench for the serial host command port.
`timescale 1ns/100ps
`default_nettype none
module test_spi_host_command_port;
  import shcp_pkg::*;
  localparam int MSC = 20;
  localparam logic [7:0] NMS = 8'h64;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic sck;
  logic cs_n;
  logic [3:0] lane_w;
  logic [3:0] lane_q;
  logic [3:0] lane_oe;
  logic int_n;
  logic [3:0] oe_seen;
  logic [7:0] q [$];
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;

  // ----------------------------------------------------------------
  // Clock, design and host.
  // ----------------------------------------------------------------
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc++;

  shcp_host_port #(.MS_CYCLES_P(MSC)) i_shcp_host_port (
    .clk_sys_in(clk_sys), .arst_n_in(arst_n), .sck_in(sck), .cs_n_in(cs_n),
    .lane_in(lane_w), .lane_out(lane_q), .lane_oe_out(lane_oe), .int_n_out(int_n));

  shcp_host_model i_shcp_host_model (
    .clk_sys_in(clk_sys), .lane_out_in(lane_q), .lane_oe_in(lane_oe),
    .sck_out(sck), .cs_n_out(cs_n), .lane_w_out(lane_w));

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // One whole transaction; the enables are caught before deselect, where they still stand.
  task automatic xact(input logic wr, input logic fifo, input logic [11:0] a, input logic [7:0] d [$]);
    logic [7:0] r;
    q = {};
    @(posedge clk_sys);
    #1;
    i_shcp_host_model.open_frame();
    i_shcp_host_model.xfer({wr, fifo, 6'h00}, 1, r);
    i_shcp_host_model.xfer({4'h0, a[11:8]}, 1, r);
    i_shcp_host_model.xfer(a[7:0], 1, r);
    foreach (d[i]) begin
      i_shcp_host_model.xfer(d[i], wr, r);
      q.push_back(r);
    end
    oe_seen = lane_oe;
    i_shcp_host_model.close_frame();
  endtask : xact

  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp, input string what);
    xact(1'b0, 1'b0, a, {8'h00});
    check(16'(q[0]), 16'(exp), what);
  endtask : rdchk

  // Reset is held for six cycles; the second use lands in mid-run.
  task automatic do_reset();
    @(posedge clk_sys);
    #1 arst_n = 1'b0;
    i_shcp_host_model.width = 1;
    repeat (6) @(posedge clk_sys);
    check(16'(int_n), 16'h0001, "interrupt idle in reset");
    check(16'(lane_oe), 16'h0000, "lanes released in reset");
    #1 arst_n = 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask : do_reset

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdchk(REG_LANE_WIDTH, 8'h00, "width after reset");
    check(16'(oe_seen), 16'h0002, "single mode drives lane one only");
    rdchk(12'h020, 8'h00, "unmapped read");
    check(16'(lane_oe), 16'h0000, "no drive while deselected");
    $display("test reset done");
  endtask : t_reset

  // Clocking a width write with select high must change nothing.
  task automatic t_deselect();
    logic [7:0] r;
    @(posedge clk_sys);
    #1;
    i_shcp_host_model.xfer(8'h80, 1, r);
    i_shcp_host_model.xfer(8'h00, 1, r);
    i_shcp_host_model.xfer(8'h00, 1, r);
    i_shcp_host_model.xfer(8'h02, 1, r);
    #400;
    rdchk(REG_LANE_WIDTH, 8'h00, "width unchanged while deselected");
    $display("test deselect done");
  endtask : t_deselect

  // Only the defined codes are written; the reserved one stays unused.
  task automatic t_lanes();
    logic [1:0] codes [2] = '{LANE_DUAL, LANE_QUAD};
    foreach (codes[k]) begin
      xact(1'b1, 1'b0, REG_LANE_WIDTH, {8'(codes[k])});
      i_shcp_host_model.width = (codes[k] == LANE_DUAL) ? 2 : 4;
      rdchk(REG_LANE_WIDTH, {6'h00, codes[k]}, "width read back in new mode");
      check(16'(oe_seen), (codes[k] == LANE_DUAL) ? 16'h0003 : 16'h000F, "read lanes driven");
      xact(1'b1, 1'b1, 12'hFFF, {8'hA5, 8'h3C});
      xact(1'b0, 1'b1, 12'hFFF, {8'h00, 8'h00});
      check({q[0], q[1]}, 16'hA53C, "FIFO bytes across the 4K wrap");
      rdchk(REG_STATUS, 8'h00, "no FIFO byte dropped");
    end
    do_reset();
    rdchk(REG_LANE_WIDTH, 8'h00, "single mode after second reset");
    $display("test lanes done");
  endtask : t_lanes

  // A no-op then a timed interrupt; the read pointer lags until each command ends.
  task automatic t_engine();
    int t0;
    xact(1'b1, 1'b1, 12'h000, {8'h07, OP_TIMED_INT, NMS});
    xact(1'b1, 1'b0, REG_CMD_WR_LO, {8'h03});
    // The low byte alone already opens the window, so the timer starts here.
    t0 = cyc;
    xact(1'b1, 1'b0, REG_CMD_WR_HI, {8'h00});
    rdchk(REG_CMD_RD_LO, 8'h01, "pointer past the no-op only");
    check(16'(int_n), 16'h0001, "interrupt not yet due");
    while (int_n !== 1'b0 && cyc - t0 < int'(NMS) * MSC + 100) begin
      @(posedge clk_sys);
      #1;
    end
    check(16'(cyc - t0 >= int'(NMS) * MSC - 15 && cyc - t0 <= int'(NMS) * MSC + 5), 16'h0001, "delay");
    rdchk(REG_CMD_RD_LO, 8'h03, "pointer past timed command");
    rdchk(REG_CMD_RD_HI, 8'h00, "pointer high byte");
    rdchk(REG_INT_FLAG, 8'h01, "flag pending");
    check(16'(int_n), 16'h0000, "interrupt pin low while pending");
    xact(1'b1, 1'b0, REG_INT_FLAG, {8'h01});
    check(16'(int_n), 16'h0001, "interrupt pin released");
    rdchk(REG_INT_FLAG, 8'h00, "flag cleared");
    $display("test engine done");
  endtask : t_engine

  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence.
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // The tests need well under a millisecond; two give ample margin.
  initial begin
    #2000000;
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    do_reset();
    t_reset();
    t_deselect();
    t_lanes();
    t_engine();
    give_verdict();
  end
endmodule : test_spi_host_command_port
`default_nettype wire
